// ---- logic/wmi_pkg.sv ----
// Constants and types for the wake, measurement and interrupt block.
// Contract
// - After reset measurement mode is off, wake inputs normal, pass switch open.
// - Measurement enabled closes the pass switch only in normal mode.
// - Measurement enabled disables pulls of inputs one and two and gates them.
// - Pull, filter and wake-enable writes for inputs one, two stay stored but are ignored.
// - Measurement enabled stops status and level updates for inputs one and two.
// - Sleep in measurement mode with only inputs one/two as wake sources sets failure, enters restart.
// - Wake filter times are 16 us or 64 us from the oscillator.
// - Interrupt output is push-pull, high when idle, low during a pulse.
// - In normal and stop mode each pulse lasts the pulse width, self releasing.
// - Output stays high at least the minimum gap between pulses.
// - Pulse width and minimum gap are both 100 us.
// - An interrupt never changes the operating mode by itself.
// - Class bit 0 lets only enabled latched wake events interrupt.
// - Class bit 1 adds latched failures; live level status never interrupts.
// - Restart or fail-safe errors, power-on and device status bits never interrupt.
// - A stop command interrupts if any wake status bit is still set.
// - Host-visible status is refreshed at each falling edge of a pulse.
// - Latched events stay set until the host clears them.
// - In init mode the interrupt pin is the configuration select input.
package wmi_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SHORT_FILTER_US = 16;
    localparam int unsigned LONG_FILTER_US = 64;
    localparam int unsigned IRQ_WIDTH_US = 100;
    localparam int unsigned IRQ_MIN_GAP_US = 100;
    localparam int unsigned SHORT_FILTER_CYC = SHORT_FILTER_US * CLK_MHZ;
    localparam int unsigned LONG_FILTER_CYC = LONG_FILTER_US * CLK_MHZ;
    localparam int unsigned IRQ_WIDTH_CYC = IRQ_WIDTH_US * CLK_MHZ;
    localparam int unsigned IRQ_MIN_GAP_CYC = IRQ_MIN_GAP_US * CLK_MHZ;
    localparam int unsigned NUM_WAKE = 3;
    localparam int unsigned NUM_FAIL = 8;
    localparam logic [2:0] WAKE_STAT_RESET = 3'h0;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;
    localparam logic [1:0] FILT_STATIC_SHORT = 2'h0;
    localparam logic [1:0] FILT_STATIC_LONG = 2'h1;
    // Operating modes of the device, driven in from the mode controller.
    typedef enum logic [2:0] {
        WMI_MODE_INIT = 3'h0,
        WMI_MODE_NORMAL = 3'h1,
        WMI_MODE_STOP = 3'h2,
        WMI_MODE_SLEEP = 3'h3,
        WMI_MODE_RESTART = 3'h4,
        WMI_MODE_FAILSAFE = 3'h5
    } wmi_mode_t;
endpackage : wmi_pkg

// ---- logic/wmi_top.sv ----
// Wake filtering, measurement gating and timed interrupt pulse generation.
module wmi_top #(
    parameter int unsigned IRQ_WIDTH_CYCLES = wmi_pkg::IRQ_WIDTH_CYC,
    parameter int unsigned IRQ_GAP_CYCLES = wmi_pkg::IRQ_MIN_GAP_CYC,
    parameter int unsigned LONG_FILT_CYCLES = wmi_pkg::LONG_FILTER_CYC,
    parameter int unsigned SHORT_FILT_CYCLES = wmi_pkg::SHORT_FILTER_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] mode,
    input wire logic measure_mode_enable,
    input wire logic irq_class_global,
    input wire logic [2:0] wake_in,
    input wire logic [5:0] wake_pull_config,
    input wire logic [5:0] wake_filter_config,
    input wire logic [2:0] wake_source_enables,
    input wire logic [1:0] gpio_wake_in,
    input wire logic [1:0] gpio_wake_enable,
    input wire logic [7:0] fail_event,
    input wire logic [7:0] fail_irq_capable,
    input wire logic stop_cmd,
    input wire logic sleep_cmd,
    input wire logic [2:0] clr_wake_status_a,
    input wire logic [1:0] clr_wake_status_b,
    input wire logic [7:0] clr_fail_status,
    input wire logic irq_pin_in,
    output logic irq_pin_n,
    output logic irq_pin_oe,
    output logic measure_pass_switch,
    output logic [2:0] pull_up_en,
    output logic [2:0] pull_down_en,
    output logic [2:0] wake_event_status_a,
    output logic [1:0] wake_event_status_b,
    output logic [2:0] wake_pin_level_status,
    output logic [7:0] fail_status,
    output logic spi_fail_set,
    output logic restart_req,
    output logic sleep_grant,
    output logic config_select
);
    localparam int CW = 16;

    initial
    begin
        if (IRQ_WIDTH_CYCLES < 2 || IRQ_WIDTH_CYCLES >= (1 << CW) ||
            IRQ_GAP_CYCLES < 2 || IRQ_GAP_CYCLES >= (1 << CW) ||
            LONG_FILT_CYCLES < 2 || LONG_FILT_CYCLES >= (1 << CW) ||
            SHORT_FILT_CYCLES < 2 || SHORT_FILT_CYCLES > LONG_FILT_CYCLES)
        begin
            $error("wmi_top: cycle counts out of range.");
        end
    end

    typedef enum logic [1:0] {
        WMI_IDLE,
        WMI_PULSE,
        WMI_GAP
    } wmi_irq_state_t;

    // Decodes whether a mode is one in which the pulse output is live.
    function automatic logic wmi_irq_mode(input logic [2:0] m);
        wmi_irq_mode = (m == wmi_pkg::WMI_MODE_NORMAL) || (m == wmi_pkg::WMI_MODE_STOP);
    endfunction : wmi_irq_mode

    logic [2:0] gate_mask;
    logic meas_active;
    logic [2:0] filt_level_ff;
    logic [2:0] raw_prev_ff;
    logic [2:0] wake_edge;
    logic [2:0] wake_stat_ff;
    logic [1:0] gpio_stat_ff;
    logic [1:0] gpio_prev_ff;
    logic [7:0] fail_stat_ff;
    logic pending_ff;
    logic new_event;
    logic [2:0] wake_set;
    logic [1:0] gpio_set;
    logic [7:0] fail_set;
    wmi_irq_state_t irq_state_ff;
    logic [CW-1:0] irq_cnt_ff;
    logic pulse_fall;
    logic only_gated_src;

    // Measurement mode gates inputs one and two everywhere.
    assign meas_active = measure_mode_enable;
    assign gate_mask = meas_active ? 3'h4 : 3'h7;

    // Per-input digital filter, retriggered by each threshold crossing.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_wake
            logic [CW-1:0] fcnt_ff;
            logic [CW-1:0] flimit;
            assign flimit = (wake_filter_config[2*gi +: 2] == wmi_pkg::FILT_STATIC_LONG) ?
                CW'(LONG_FILT_CYCLES) : CW'(SHORT_FILT_CYCLES);
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    raw_prev_ff[gi] <= 1'b0;
                    fcnt_ff <= '0;
                    filt_level_ff[gi] <= 1'b0;
                end
                else
                begin
                    raw_prev_ff[gi] <= wake_in[gi];
                    if (wake_in[gi] != raw_prev_ff[gi])
                    begin
                        fcnt_ff <= '0;
                    end
                    else if (wake_in[gi] != filt_level_ff[gi])
                    begin
                        if (fcnt_ff >= flimit - CW'(1))
                        begin
                            filt_level_ff[gi] <= wake_in[gi];
                            fcnt_ff <= '0;
                        end
                        else
                        begin
                            fcnt_ff <= fcnt_ff + CW'(1);
                        end
                    end
                    else
                    begin
                        fcnt_ff <= '0;
                    end
                end
            end
            // Pull source selection, including automatic following of the level.
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    pull_up_en[gi] <= 1'b0;
                    pull_down_en[gi] <= 1'b0;
                end
                else if (!gate_mask[gi])
                begin
                    pull_up_en[gi] <= 1'b0;
                    pull_down_en[gi] <= 1'b0;
                end
                else
                begin
                    unique case (wake_pull_config[2*gi +: 2])
                        wmi_pkg::PULL_NONE:
                        begin
                            pull_up_en[gi] <= 1'b0;
                            pull_down_en[gi] <= 1'b0;
                        end
                        wmi_pkg::PULL_DOWN:
                        begin
                            pull_up_en[gi] <= 1'b0;
                            pull_down_en[gi] <= 1'b1;
                        end
                        wmi_pkg::PULL_UP:
                        begin
                            pull_up_en[gi] <= 1'b1;
                            pull_down_en[gi] <= 1'b0;
                        end
                        wmi_pkg::PULL_AUTO:
                        begin
                            pull_up_en[gi] <= filt_level_ff[gi];
                            pull_down_en[gi] <= !filt_level_ff[gi];
                        end
                    endcase
                end
            end
        end
    endgenerate

    logic [2:0] filt_prev_ff;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            filt_prev_ff <= '0;
            gpio_prev_ff <= '0;
        end
        else
        begin
            filt_prev_ff <= filt_level_ff;
            gpio_prev_ff <= gpio_wake_in;
        end
    end

    // Either edge of a filtered, enabled and ungated input is a wake event.
    assign wake_edge = (filt_level_ff ^ filt_prev_ff) & gate_mask;
    assign wake_set = wake_edge & wake_source_enables;
    assign gpio_set = (gpio_wake_in ^ gpio_prev_ff) & gpio_wake_enable;
    // Only failures that software marks interrupt-capable count; fatal ones never.
    assign fail_set = fail_event & fail_irq_capable;
    assign new_event = (|wake_set) || (|gpio_set) ||
        (irq_class_global && (|fail_set)) ||
        (stop_cmd && ((|wake_stat_ff) || (|gpio_stat_ff)));

    logic [2:0] fresh_a_ff;
    logic [1:0] fresh_b_ff;
    logic [7:0] fresh_f_ff;

    // Sticky internal status; a set in the clear cycle wins.
    // Bits set after the last host copy survive a clear of that copy.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_stat_ff <= wmi_pkg::WAKE_STAT_RESET;
            gpio_stat_ff <= '0;
            fail_stat_ff <= '0;
            fresh_a_ff <= '0;
            fresh_b_ff <= '0;
            fresh_f_ff <= '0;
        end
        else
        begin
            wake_stat_ff <= (wake_stat_ff & ~(clr_wake_status_a & ~fresh_a_ff)) | wake_set;
            gpio_stat_ff <= (gpio_stat_ff & ~(clr_wake_status_b & ~fresh_b_ff)) | gpio_set;
            fail_stat_ff <= (fail_stat_ff & ~(clr_fail_status & ~fresh_f_ff)) | fail_event;
            fresh_a_ff <= (pulse_fall ? 3'h0 : fresh_a_ff) | wake_set;
            fresh_b_ff <= (pulse_fall ? 2'h0 : fresh_b_ff) | gpio_set;
            fresh_f_ff <= (pulse_fall ? 8'h0 : fresh_f_ff) | fail_event;
        end
    end

    // Host-visible copies refresh on the falling edge of each pulse.
    assign pulse_fall = (irq_state_ff == WMI_IDLE) && pending_ff &&
        wmi_irq_mode(mode);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_event_status_a <= '0;
            wake_event_status_b <= '0;
            fail_status <= '0;
        end
        else if (pulse_fall)
        begin
            wake_event_status_a <= wake_stat_ff;
            wake_event_status_b <= gpio_stat_ff;
            fail_status <= fail_stat_ff;
        end
        else
        begin
            wake_event_status_a <= wake_event_status_a & ~clr_wake_status_a;
            wake_event_status_b <= wake_event_status_b & ~clr_wake_status_b;
            fail_status <= fail_status & ~clr_fail_status;
        end
    end

    // Live levels, frozen for gated inputs and outside normal and stop modes.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_pin_level_status <= '0;
        end
        else if (wmi_irq_mode(mode))
        begin
            wake_pin_level_status <= (filt_level_ff & gate_mask) |
                (wake_pin_level_status & ~gate_mask);
        end
    end

    // Pending request held across a pulse and its gap.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pending_ff <= 1'b0;
        end
        else
        begin
            pending_ff <= new_event || (pending_ff && !pulse_fall);
        end
    end

    // Pulse timer: low for the width, then high for at least the gap.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_state_ff <= WMI_IDLE;
            irq_cnt_ff <= '0;
        end
        else
        begin
            unique case (irq_state_ff)
                WMI_IDLE:
                begin
                    if (pulse_fall)
                    begin
                        irq_state_ff <= WMI_PULSE;
                        irq_cnt_ff <= '0;
                    end
                end
                WMI_PULSE:
                begin
                    if (irq_cnt_ff == CW'(IRQ_WIDTH_CYCLES - 1))
                    begin
                        irq_state_ff <= WMI_GAP;
                        irq_cnt_ff <= '0;
                    end
                    else
                    begin
                        irq_cnt_ff <= irq_cnt_ff + CW'(1);
                    end
                end
                WMI_GAP:
                begin
                    if (irq_cnt_ff == CW'(IRQ_GAP_CYCLES - 1))
                    begin
                        irq_state_ff <= WMI_IDLE;
                        irq_cnt_ff <= '0;
                    end
                    else
                    begin
                        irq_cnt_ff <= irq_cnt_ff + CW'(1);
                    end
                end
                default:
                begin
                    irq_state_ff <= WMI_IDLE;
                end
            endcase
        end
    end

    // Push-pull driver; released in init mode so the pin selects configuration.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_pin_n <= 1'b1;
            irq_pin_oe <= 1'b0;
            config_select <= 1'b0;
        end
        else
        begin
            irq_pin_n <= !(pulse_fall || (irq_state_ff == WMI_PULSE &&
                irq_cnt_ff != CW'(IRQ_WIDTH_CYCLES - 1)));
            irq_pin_oe <= (mode != wmi_pkg::WMI_MODE_INIT);
            if (mode == wmi_pkg::WMI_MODE_INIT)
            begin
                config_select <= irq_pin_in;
            end
        end
    end

    // Pass switch closed only with measurement on and in normal mode.
    assign only_gated_src = meas_active && (|wake_source_enables[1:0]) &&
        !wake_source_enables[2] && !(|gpio_wake_enable);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            measure_pass_switch <= 1'b0;
            spi_fail_set <= 1'b0;
            restart_req <= 1'b0;
            sleep_grant <= 1'b0;
        end
        else
        begin
            measure_pass_switch <= meas_active && (mode == wmi_pkg::WMI_MODE_NORMAL);
            spi_fail_set <= sleep_cmd && only_gated_src;
            restart_req <= sleep_cmd && only_gated_src;
            sleep_grant <= sleep_cmd && !only_gated_src;
        end
    end

    AST_SWITCH_MODE: assert property (@(posedge mclk) disable iff (!resetn)
        measure_pass_switch |-> $past(meas_active) && $past(mode) == wmi_pkg::WMI_MODE_NORMAL)
        else $error("Pass switch closed outside normal measurement.");
    AST_GATED_PULLS: assert property (@(posedge mclk) disable iff (!resetn)
        $past(meas_active) |-> pull_up_en[1:0] == 2'h0 && pull_down_en[1:0] == 2'h0)
        else $error("Pull sources active on gated inputs.");
    AST_GATED_STATUS: assert property (@(posedge mclk) disable iff (!resetn)
        meas_active |-> wake_set[1:0] == 2'h0)
        else $error("Gated input set wake status.");
    AST_SLEEP_REDIRECT: assert property (@(posedge mclk) disable iff (!resetn)
        sleep_cmd && only_gated_src |=> spi_fail_set && restart_req && !sleep_grant)
        else $error("Sleep not redirected to restart.");
    sequence s_pulse_start;
        $fell(irq_pin_n);
    endsequence
    AST_PULSE_LOW: assert property (@(posedge mclk) disable iff (!resetn)
        s_pulse_start |-> !irq_pin_n [*8])
        else $error("Interrupt pulse released early.");
    // Counts consecutive low cycles of the pin so a stuck pulse is caught.
    logic [CW-1:0] low_run_ff;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_run_ff <= '0;
        end
        else if (!irq_pin_n)
        begin
            low_run_ff <= low_run_ff + CW'(1);
        end
        else
        begin
            low_run_ff <= '0;
        end
    end
    AST_PULSE_ENDS: assert property (@(posedge mclk) disable iff (!resetn)
        low_run_ff <= CW'(IRQ_WIDTH_CYCLES))
        else $error("Interrupt pulse never released.");
    AST_GAP_HIGH: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(irq_pin_n) |-> irq_pin_n [*8])
        else $error("Gap between pulses too short.");
    AST_CLASS_ONE: assert property (@(posedge mclk) disable iff (!resetn)
        !irq_class_global && !(|wake_set) && !(|gpio_set) && !stop_cmd |->
        new_event == 1'b0)
        else $error("Non-wake event raised interrupt in wake class.");
    AST_STOP_IRQ: assert property (@(posedge mclk) disable iff (!resetn)
        stop_cmd && (|wake_stat_ff) |=> pending_ff)
        else $error("Stop with wake status did not request interrupt.");
    AST_STICKY: assert property (@(posedge mclk) disable iff (!resetn)
        $past(wake_stat_ff[2]) && !$past(clr_wake_status_a[2]) |-> wake_stat_ff[2])
        else $error("Wake status lost without clear.");
    AST_INIT_RELEASE: assert property (@(posedge mclk) disable iff (!resetn)
        $past(mode) == wmi_pkg::WMI_MODE_INIT |-> !irq_pin_oe)
        else $error("Interrupt pin driven in init mode.");
endmodule : wmi_top

// ---- verif/wmi_host_model.sv ----
// Host model that reads and clears the status copies after each interrupt pulse.
module wmi_host_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic auto_clear,
    input wire logic irq_pin_n,
    input wire logic [2:0] wake_event_status_a,
    input wire logic [1:0] wake_event_status_b,
    input wire logic [7:0] fail_status,
    output logic [2:0] clr_wake_status_a,
    output logic [1:0] clr_wake_status_b,
    output logic [7:0] clr_fail_status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_prev_ff;
    logic [1:0] reread_ff;
    // After the pulse ends, clear what is set, then read once more and clear again.
    always @(negedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_prev_ff <= 1'b1;
            reread_ff <= 2'h0;
            clr_wake_status_a <= 3'h0;
            clr_wake_status_b <= 2'h0;
            clr_fail_status <= 8'h0;
        end
        else
        begin
            irq_prev_ff <= irq_pin_n;
            reread_ff <= {reread_ff[0], auto_clear & irq_pin_n & ~irq_prev_ff};
            clr_wake_status_a <= 3'h0;
            clr_wake_status_b <= 2'h0;
            clr_fail_status <= 8'h0;
            if (auto_clear && ((irq_pin_n && !irq_prev_ff) || reread_ff[1]))
            begin
                clr_wake_status_a <= wake_event_status_a;
                clr_wake_status_b <= wake_event_status_b;
                clr_fail_status <= fail_status;
            end
        end
    end
endmodule : wmi_host_model

// ---- verif/wake_measure_and_interrupt_bench.sv ----
// Self-checking bench for the wake, measurement and interrupt block.
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module wake_measure_and_interrupt_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 20;
    localparam int G = 20;
    localparam int LF = 8;
    localparam int SF = 4;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] mode = wmi_pkg::WMI_MODE_INIT;
    logic measure_mode_enable = 1'b0;
    logic irq_class_global = 1'b0;
    logic [2:0] wake_in = 3'h0;
    logic [5:0] wake_pull_config = 6'h2a;
    logic [5:0] wake_filter_config = 6'h0;
    logic [2:0] wake_source_enables = 3'h7;
    logic [1:0] gpio_wake_in = 2'h0;
    logic [1:0] gpio_wake_enable = 2'h3;
    logic [7:0] fail_event = 8'h0;
    logic [7:0] fail_irq_capable = 8'h0;
    logic stop_cmd = 1'b0;
    logic sleep_cmd = 1'b0;
    logic irq_pin_in = 1'b1;
    logic auto_clear = 1'b1;
    logic [2:0] clr_a;
    logic [1:0] clr_b;
    logic [7:0] clr_f;
    logic irq_pin_n, irq_pin_oe, measure_pass_switch, spi_fail_set, restart_req;
    logic sleep_grant, config_select;
    logic [2:0] pull_up_en, pull_down_en, wake_event_status_a, wake_pin_level_status;
    logic [1:0] wake_event_status_b;
    logic [7:0] fail_status;
    int fail_count = 0;
    int total_checks = 0;
    int n;
    int idx;
    logic f_seen, r_seen, g_seen;

    wmi_top #(.IRQ_WIDTH_CYCLES(W), .IRQ_GAP_CYCLES(G), .LONG_FILT_CYCLES(LF),
        .SHORT_FILT_CYCLES(SF)) wmi_top_inst (.mclk(mclk), .resetn(resetn), .mode(mode),
        .measure_mode_enable(measure_mode_enable), .irq_class_global(irq_class_global),
        .wake_in(wake_in), .wake_pull_config(wake_pull_config),
        .wake_filter_config(wake_filter_config), .wake_source_enables(wake_source_enables),
        .gpio_wake_in(gpio_wake_in), .gpio_wake_enable(gpio_wake_enable),
        .fail_event(fail_event), .fail_irq_capable(fail_irq_capable), .stop_cmd(stop_cmd),
        .sleep_cmd(sleep_cmd), .clr_wake_status_a(clr_a), .clr_wake_status_b(clr_b),
        .clr_fail_status(clr_f), .irq_pin_in(irq_pin_in), .irq_pin_n(irq_pin_n),
        .irq_pin_oe(irq_pin_oe), .measure_pass_switch(measure_pass_switch),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .wake_event_status_a(wake_event_status_a), .wake_event_status_b(wake_event_status_b),
        .wake_pin_level_status(wake_pin_level_status), .fail_status(fail_status),
        .spi_fail_set(spi_fail_set), .restart_req(restart_req), .sleep_grant(sleep_grant),
        .config_select(config_select));

    wmi_host_model wmi_host_model_inst (.mclk(mclk), .resetn(resetn), .auto_clear(auto_clear),
        .irq_pin_n(irq_pin_n), .wake_event_status_a(wake_event_status_a),
        .wake_event_status_b(wake_event_status_b), .fail_status(fail_status),
        .clr_wake_status_a(clr_a), .clr_wake_status_b(clr_b), .clr_fail_status(clr_f));

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask : tick

    // Waits up to lim cycles for a low pulse; a missing wanted pulse ends the run.
    task automatic await_irq(input int lim, input bit want, output int c);
        c = 0;
        while (irq_pin_n !== 1'b0 && c < lim)
        begin
            tick(1);
            c++;
        end
        if (want && c == lim)
        begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
            end_sim();
        end
    endtask : await_irq

    // Counts the cycles that the output stays low.
    task automatic low_len(output int c);
        c = 0;
        while (irq_pin_n === 1'b0 && c < 1000)
        begin
            tick(1);
            c++;
        end
        `CHK(irq_pin_n, 1'b1)
    endtask : low_len

    // Sends a single-cycle sleep command and gathers the answer pulses.
    task automatic try_sleep();
        f_seen = 1'b0;
        r_seen = 1'b0;
        g_seen = 1'b0;
        sleep_cmd = 1'b1;
        tick(1);
        sleep_cmd = 1'b0;
        repeat (4)
        begin
            f_seen |= spi_fail_set;
            r_seen |= restart_req;
            g_seen |= sleep_grant;
            tick(1);
        end
    endtask : try_sleep

    // Main sequence.
    initial
    begin
        void'($urandom(32'h2e7b8492));
        repeat (16) @(posedge mclk);
        `CHK(irq_pin_n, 1'b1)
        `CHK(measure_pass_switch, 1'b0)
        tick(1);
        resetn = 1'b1;
        tick(3);
        `CHK(config_select, 1'b1)
        `CHK(irq_pin_oe, 1'b0)
        mode = wmi_pkg::WMI_MODE_NORMAL;
        tick(3);
        `CHK(irq_pin_oe, 1'b1)
        `CHK(pull_up_en, 3'h7)
        // Glitches shorter than the randomly chosen short or long filter never wake.
        repeat (6)
        begin
            wake_in[2] = 1'b1;
            tick(wake_filter_config[5:4] == 2'h1 ? SF + 1 + $urandom % (LF - SF - 2)
                : 1 + $urandom % (SF - 2));
            wake_in[2] = 1'b0;
            await_irq(LF + 30, 1'b0, n);
            `CHK(n, LF + 30)
            wake_filter_config[5:4] = 2'($urandom % 2);
        end
        // Real wake, second event during the pulse, width and gap.
        wake_in[2] = 1'b1;
        await_irq(LF + 30, 1'b1, n);
        `CHK(wake_event_status_a, 3'h4)
        wake_in[2] = 1'b0;
        low_len(n);
        `CHK(n, W)
        await_irq(G + LF + 40, 1'b1, n);
        `CHK(n >= G, 1'b1)
        `CHK(wake_event_status_a, 3'h4)
        low_len(n);
        tick(G + 5);
        // Measurement mode gates inputs one and two.
        measure_mode_enable = 1'b1;
        tick(3);
        `CHK(measure_pass_switch, 1'b1)
        `CHK(pull_up_en, 3'h4)
        `CHK(pull_down_en, 3'h0)
        wake_in[1:0] = 2'h3;
        await_irq(LF + 30, 1'b0, n);
        `CHK(n, LF + 30)
        `CHK(wake_pin_level_status[1:0], 2'h0)
        mode = wmi_pkg::WMI_MODE_STOP;
        tick(3);
        `CHK(measure_pass_switch, 1'b0)
        mode = wmi_pkg::WMI_MODE_NORMAL;
        wake_source_enables = 3'h3;
        gpio_wake_enable = 2'h0;
        try_sleep();
        `CHK({f_seen, r_seen, g_seen}, 3'h6)
        wake_source_enables = 3'h7;
        gpio_wake_enable = 2'h3;
        try_sleep();
        `CHK({f_seen, r_seen, g_seen}, 3'h1)
        measure_mode_enable = 1'b0;
        // Failure classes with a random capable source.
        idx = $urandom % 8;
        fail_irq_capable = 8'h1 << idx;
        irq_class_global = 1'b1;
        fail_event[idx] = 1'b1;
        tick(1);
        fail_event[idx] = 1'b0;
        await_irq(20, 1'b1, n);
        `CHK(fail_status[idx], 1'b1)
        low_len(n);
        tick(G + 5);
        fail_event[(idx + 1) % 8] = 1'b1;
        tick(1);
        fail_event = 8'h0;
        await_irq(40, 1'b0, n);
        `CHK(n, 40)
        irq_class_global = 1'b0;
        fail_event[idx] = 1'b1;
        tick(1);
        fail_event = 8'h0;
        await_irq(40, 1'b0, n);
        `CHK(n, 40)
        // A wake on a general purpose input reports in the second status copy.
        gpio_wake_in[0] = 1'b1;
        await_irq(20, 1'b1, n);
        `CHK(wake_event_status_b, 2'h1)
        low_len(n);
        tick(G + 5);
        // Stop command with a wake bit left set.
        auto_clear = 1'b0;
        wake_in[2] = 1'b1;
        await_irq(LF + 30, 1'b1, n);
        tick(W + G + 10);
        mode = wmi_pkg::WMI_MODE_STOP;
        stop_cmd = 1'b1;
        tick(1);
        stop_cmd = 1'b0;
        auto_clear = 1'b1;
        await_irq(20, 1'b1, n);
        `CHK(wake_event_status_a, 3'h4)
        low_len(n);
        tick(8);
        `CHK(wake_event_status_a, 3'h0)
        end_sim();
    end
endmodule : wake_measure_and_interrupt_bench
